// [its_far_side.sv]
// far side model: rf tick sources and energy window detector
`timescale 1ns/10ps
module its_far_side (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  output logic o_ring_rf_tick,
  output logic o_booster_rf_tick,
  output logic o_energy_window
);
  logic [11:0] cnt_q;
  logic [1:0] b_q;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      b_q <= '0;
    end else begin
      cnt_q <= (cnt_q == 12'hbb7) ? '0 : cnt_q + 12'h1;
      b_q <= (b_q == 2'h2) ? '0 : b_q + 2'h1;
    end
  end
  // rf scaled down: the real ring rf runs faster than the logic clock
  assign o_ring_rf_tick = cnt_q[0];
  assign o_booster_rf_tick = (b_q == 2'h2);
  // 4 us window, wider than a revolution so every window holds a fiducial
  assign o_energy_window = (cnt_q < 12'h320);
endmodule

// [its_injection_timing_sequencer.sv]
// injection timing sequencer: fiducial divider, bucket delay and trigger sequence
`timescale 1ns/10ps
module its_injection_timing_sequencer
  import its_pkg::*;
#(
  parameter int unsigned ACCEL_CYC = ACCEL_CYC_DEF
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // ring rf reference, booster rf and energy window, synchronous samples
  input wire logic i_ring_rf_tick,
  input wire logic i_booster_rf_tick,
  input wire logic i_energy_window,
  // request
  input wire logic i_arm,
  input wire logic [BKT_W-1:0] i_target_bucket,
  input wire its_linac_dly_t i_linac_dly,
  input wire logic [DLY_W-1:0] i_ring_kick_gap,
  // phase table load
  input wire logic i_tbl_wr,
  input wire logic [TIDX_W-1:0] i_tbl_addr,
  input wire logic [PH_W-1:0] i_tbl_data,
  // outputs
  output its_trig_t o_trig,
  output logic o_fiducial,
  output logic [PH_W-1:0] o_booster_phase,
  output logic o_busy
);
  its_state_t state_q;
  logic [BKT_W-1:0] rf_div_q;
  logic [BKT_W-1:0] bkt_dly_q;
  logic bkt_run_q;
  logic target_fid;
  logic [CNT_W-1:0] seq_cnt_q;
  logic [7:0] brf_div_q;
  logic [2:0] turn_q;
  logic sync_turn;
  logic [1:0] ring_idx_q;
  logic [PH_W-1:0] phase_tbl [PHASE_TABLE_SIZE];
  its_trig_t trig_d;
  logic linac_go;

  // pulse active when count lies in [start, start+width)
  function automatic logic in_pulse(input logic [CNT_W-1:0] cnt, input logic [DLY_W-1:0] start,
                                    input int unsigned width);
    logic [CNT_W-1:0] s;
    s = CNT_W'(start);
    in_pulse = (cnt >= s) && (cnt < s + CNT_W'(width));
  endfunction

  // bucket to phase index by folding, so no divider sits in the arm path;
  // enough folds for any 9-bit bucket, even one outside the ring
  function automatic logic [TIDX_W-1:0] phase_idx(input logic [BKT_W-1:0] bkt);
    logic [BKT_W-1:0] r;
    r = bkt;
    for (int k = 0; k < (1 << BKT_W) / PHASE_TABLE_SIZE; k++) begin
      if (r >= BKT_W'(PHASE_TABLE_SIZE)) begin
        r = r - BKT_W'(PHASE_TABLE_SIZE);
      end
    end
    phase_idx = TIDX_W'(r);
  endfunction

  // ring rf divider, one fiducial every 372 rf periods
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rf_div_q <= '0;
      o_fiducial <= 1'b0;
    end else begin
      o_fiducial <= 1'b0;
      if (i_ring_rf_tick) begin
        if (rf_div_q == BKT_LAST) begin
          rf_div_q <= '0;
          o_fiducial <= 1'b1;
        end else begin
          rf_div_q <= rf_div_q + 1'b1;
        end
      end
    end
  end

  // bucket delay: count target-bucket rf periods after the fiducial
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bkt_dly_q <= '0;
      bkt_run_q <= 1'b0;
    end else if (o_fiducial) begin
      bkt_dly_q <= i_target_bucket;
      bkt_run_q <= 1'b1;
    end else if (bkt_run_q && i_ring_rf_tick) begin
      if (bkt_dly_q == '0) begin
        bkt_run_q <= 1'b0;
      end else begin
        bkt_dly_q <= bkt_dly_q - 1'b1;
      end
    end
  end
  assign target_fid = bkt_run_q && (bkt_dly_q == '0) && !o_fiducial;

  // booster phase table; the write port loads it, the bucket selects an entry
  always_ff @(posedge i_clk_sys) begin
    if (i_tbl_wr && i_tbl_addr <= TIDX_LAST) begin
      phase_tbl[i_tbl_addr] <= i_tbl_data;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_booster_phase <= '0;
    end else if (i_arm && state_q == ST_IDLE) begin
      // buckets map onto 93 phases, repeating every 93 buckets
      o_booster_phase <= phase_tbl[phase_idx(i_target_bucket)];
    end
  end

  // main sequence; one request fills one bucket
  assign linac_go = (state_q == ST_WAIT) && target_fid && i_energy_window;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      seq_cnt_q <= '0;
      ring_idx_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          seq_cnt_q <= '0;
          ring_idx_q <= '0;
          if (i_arm) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (linac_go) begin
            state_q <= ST_LINAC;
          end
        end
        ST_LINAC: begin
          seq_cnt_q <= seq_cnt_q + 1'b1;
          if (seq_cnt_q == CNT_W'(ACCEL_CYC)) begin
            state_q <= ST_ACCEL;
          end
        end
        ST_ACCEL: begin
          if (sync_turn) begin
            state_q <= ST_EXTR;
            seq_cnt_q <= '0;
          end
        end
        ST_EXTR: begin
          seq_cnt_q <= '0;
          state_q <= ST_RING;
        end
        ST_RING: begin
          seq_cnt_q <= seq_cnt_q + 1'b1;
          if (seq_cnt_q == CNT_W'(i_ring_kick_gap)) begin
            seq_cnt_q <= '0;
            ring_idx_q <= ring_idx_q + 1'b1;
            if (ring_idx_q == 2'h2) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // booster divider: 160 rf periods per turn, then 7 turns; linac start resets it
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      brf_div_q <= '0;
      turn_q <= '0;
    end else if (linac_go) begin
      brf_div_q <= '0;
      turn_q <= '0;
    end else if (i_booster_rf_tick) begin
      if (brf_div_q == BRF_LAST) begin
        brf_div_q <= '0;
        turn_q <= (turn_q == TURN_LAST) ? 3'h0 : turn_q + 1'b1;
      end else begin
        brf_div_q <= brf_div_q + 1'b1;
      end
    end
  end
  assign sync_turn = i_booster_rf_tick && (brf_div_q == BRF_LAST) && (turn_q == TURN_LAST);

  // trigger decode; every trigger idle outside its window
  always_comb begin
    trig_d = '0;
    if (state_q == ST_LINAC) begin
      trig_d.modulator = in_pulse(seq_cnt_q, i_linac_dly.modulator, KLY_PULSE_CYC);
      trig_d.drive_amp = in_pulse(seq_cnt_q, i_linac_dly.drive_amp, KLY_PULSE_CYC);
      // the kicker delay already leads the beam by the flat-top length
      trig_d.inj_kicker = in_pulse(seq_cnt_q, i_linac_dly.inj_kicker, TRIG_PULSE_CYC);
      // chopper sweep width sets the 3-5 bunch admission, fixed outside this block
      trig_d.chopper = in_pulse(seq_cnt_q, i_linac_dly.chopper, TRIG_PULSE_CYC);
      trig_d.septum = in_pulse(seq_cnt_q, i_linac_dly.septum, TRIG_PULSE_CYC);
    end
    if (state_q == ST_EXTR) begin
      trig_d.extr_kicker = 1'b1;
    end
    if (state_q == ST_RING && seq_cnt_q == '0) begin
      trig_d.ring_kicker[ring_idx_q] = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trig <= '0;
    end else begin
      o_trig <= trig_d;
    end
  end
  assign o_busy = (state_q != ST_IDLE);
endmodule

// [its_pkg.sv]
// package: constants, states and carriers for the injection timing sequencer
package its_pkg;
  // ring and booster geometry
  localparam int unsigned RING_HARMONIC_NUMBER = 372;
  localparam int unsigned BOOSTER_HARMONIC = 160;
  localparam int unsigned SYNC_TURNS = 7;
  localparam int unsigned PHASE_TABLE_SIZE = 93;
  localparam real RING_RF_MHZ = 476.337;
  localparam real REV_FREQ_MHZ = 1.2805;
  // clock of the logic (ring rf reference distribution into the fabric)
  localparam real CLK_MHZ = 200.0;
  localparam real CLK_NS = 1000.0 / CLK_MHZ;
  // fixed pulse and delay times
  localparam real KLY_PULSE_US = 2.0;
  localparam real ACCEL_MS = 36.0;
  localparam real KICK_FLAT_NS = 260.0;
  localparam real KICK_FALL_NS = 300.0;
  localparam real BUNCH_RETURN_NS = 446.0;
  localparam real TRIG_PULSE_NS = 100.0;
  localparam int unsigned KLY_PULSE_CYC = int'($floor(KLY_PULSE_US * 1000.0 / CLK_NS));
  localparam int unsigned ACCEL_CYC_DEF = int'($ceil(ACCEL_MS * 1.0e6 / CLK_NS));
  // kicker fires so the beam arrives at the flat-top end; the fall must finish
  // before the bunch returns, so the fall time alone must stay under the return time
  localparam int unsigned KICK_LEAD_CYC = int'($floor(KICK_FLAT_NS / CLK_NS));
  localparam int unsigned TRIG_PULSE_CYC = int'($floor(TRIG_PULSE_NS / CLK_NS));
  // widths
  localparam int unsigned BKT_W = 9;
  localparam int unsigned DLY_W = 16;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned PH_W = 8;
  localparam int unsigned TIDX_W = 7;
  localparam logic [BKT_W-1:0] BKT_LAST = BKT_W'(RING_HARMONIC_NUMBER - 1);
  localparam logic [7:0] BRF_LAST = 8'(BOOSTER_HARMONIC - 1);
  localparam logic [2:0] TURN_LAST = 3'(SYNC_TURNS - 1);
  localparam logic [TIDX_W-1:0] TIDX_LAST = TIDX_W'(PHASE_TABLE_SIZE - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_LINAC = 3'h3,
    ST_ACCEL = 3'h2,
    ST_EXTR = 3'h6,
    ST_RING = 3'h7
  } its_state_t;

  // fixed delays from the qualified fiducial, in clock cycles
  typedef struct packed {
    logic [DLY_W-1:0] modulator;
    logic [DLY_W-1:0] drive_amp;
    logic [DLY_W-1:0] inj_kicker;
    logic [DLY_W-1:0] chopper;
    logic [DLY_W-1:0] septum;
  } its_linac_dly_t;

  typedef struct packed {
    logic modulator;
    logic drive_amp;
    logic inj_kicker;
    logic chopper;
    logic septum;
    logic extr_kicker;
    logic [2:0] ring_kicker;
  } its_trig_t;
endpackage

// [its_seq_props.sv]
// checker: timing relations seen at the sequencer ports
`timescale 1ns/10ps
module its_seq_props
  import its_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ring_rf_tick,
  input wire logic [DLY_W-1:0] i_ring_kick_gap,
  input wire its_trig_t o_trig,
  input wire logic o_fiducial,
  input wire logic [PH_W-1:0] o_booster_phase,
  input wire logic o_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [8:0] tick_q;
  logic seen_q;
  logic [15:0] mod_run_q;
  logic [15:0] chop_run_q;
  logic [16:0] gap_q;
  // run counters stand in for long repetitions
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_q <= '0;
      seen_q <= 1'b0;
      mod_run_q <= '0;
      chop_run_q <= '0;
      gap_q <= '0;
    end else begin
      tick_q <= o_fiducial ? 9'(i_ring_rf_tick) : tick_q + 9'(i_ring_rf_tick);
      seen_q <= seen_q | o_fiducial;
      mod_run_q <= o_trig.modulator ? mod_run_q + 16'h1 : '0;
      chop_run_q <= o_trig.chopper ? chop_run_q + 16'h1 : '0;
      gap_q <= (o_trig.ring_kicker[0] | o_trig.ring_kicker[1]) ? 17'h1 : gap_q + 17'h1;
    end
  end
  sequence s_one_shot;
    o_busy ##1 !o_trig.extr_kicker;
  endsequence
  a_fid_count: assert property (o_fiducial && seen_q |-> tick_q == 9'h174)
    else $error("fiducial spacing wrong");
  a_fid_single: assert property (o_fiducial |=> !o_fiducial)
    else $error("fiducial wider than one cycle");
  a_rst_quiet: assert property ($rose(i_reset_n) |-> o_trig == '0 && !o_busy)
    else $error("outputs active after reset");
  a_start_quiet: assert property ($rose(o_busy) |-> o_trig == '0)
    else $error("trigger before sequence start");
  a_kly_width: assert property ($fell(o_trig.modulator) |-> mod_run_q == 16'h190)
    else $error("modulator width wrong");
  a_chop_width: assert property ($fell(o_trig.chopper) |-> chop_run_q == 16'h14)
    else $error("chopper width wrong");
  a_extr_once: assert property (o_trig.extr_kicker |-> s_one_shot)
    else $error("extraction pulse wrong");
  a_ring_gap: assert property (o_trig.ring_kicker[1] || o_trig.ring_kicker[2] |->
    gap_q == 17'(i_ring_kick_gap) + 17'h1) else $error("ring kicker gap wrong");
  a_phase_hold: assert property (o_busy && $past(o_busy) |-> $stable(o_booster_phase))
    else $error("phase moved mid sequence");
endmodule
bind its_injection_timing_sequencer its_seq_props chk_u (.i_clk_sys, .i_reset_n,
  .i_ring_rf_tick, .i_ring_kick_gap, .o_trig, .o_fiducial, .o_booster_phase, .o_busy);

// [test_injection_timing_sequencer.sv]
// testbench: reset, fiducial and fill sequence checks
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_injection_timing_sequencer
  import its_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic ring_tick, boost_tick, window, i_arm = 1'b0, i_tbl_wr = 1'b0;
  logic [BKT_W-1:0] i_target_bucket = '0;
  its_linac_dly_t i_linac_dly = {16'h000a, 16'h000a, 16'h0040, 16'h0050, 16'h0060};
  logic [DLY_W-1:0] i_ring_kick_gap = 16'h0005;
  logic [TIDX_W-1:0] i_tbl_addr = '0;
  logic [PH_W-1:0] i_tbl_data = '0;
  its_trig_t o_trig;
  logic o_fiducial, o_busy;
  logic [PH_W-1:0] o_booster_phase;
  int bad_count = 0;
  int n_tests = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  its_far_side far_u (.i_clk_sys, .i_reset_n, .o_ring_rf_tick(ring_tick),
    .o_booster_rf_tick(boost_tick), .o_energy_window(window));
  // accel shortened so a fill fits in a few thousand cycles
  its_injection_timing_sequencer #(.ACCEL_CYC(2000)) dut_u (.i_clk_sys, .i_reset_n,
    .i_ring_rf_tick(ring_tick), .i_booster_rf_tick(boost_tick), .i_energy_window(window),
    .i_arm, .i_target_bucket, .i_linac_dly, .i_ring_kick_gap, .i_tbl_wr, .i_tbl_addr,
    .i_tbl_data, .o_trig, .o_fiducial, .o_booster_phase, .o_busy);
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic t_quiet();
    `CHK("trig", 9'h0, o_trig)
    `CHK("busy", 1'b0, o_busy)
  endtask
  task automatic t_fid();
    int n;
    for (n = 0; n < 2000 && o_fiducial !== 1'b1; n++) tick();
    n = 0;
    do begin
      tick();
      n++;
    end while (o_fiducial !== 1'b1 && n < 2000);
    `CHK("fid_period", 744, n)
  endtask
  task automatic t_fill(input logic [BKT_W-1:0] bkt, input logic [PH_W-1:0] ph);
    int n, idle, mw, dw, kw, cw, sw, ne, t_m, t_m0, t_k0, t_f, t_e, t_r0, t_r2;
    {idle, mw, dw, kw, cw, sw, ne, t_m, t_m0, t_k0, t_f, t_e, t_r0, t_r2} = '0;
    @(posedge i_clk_sys);
    i_tbl_wr <= 1'b1;
    i_tbl_addr <= TIDX_W'(bkt % 9'h5d);
    i_tbl_data <= ph;
    i_target_bucket <= bkt;
    @(posedge i_clk_sys);
    i_tbl_wr <= 1'b0;
    i_arm <= 1'b1;
    @(posedge i_clk_sys) i_arm <= 1'b0;
    tick();
    `CHK("busy", 1'b1, o_busy)
    `CHK("phase", ph, o_booster_phase)
    // a second request while busy must be dropped
    @(posedge i_clk_sys) i_arm <= 1'b1;
    @(posedge i_clk_sys) i_arm <= 1'b0;
    for (n = 0; n < 20000 && idle < 8; n++) begin
      tick();
      idle = (o_busy === 1'b1) ? 0 : idle + 1;
      mw += int'(o_trig.modulator === 1'b1);
      dw += int'(o_trig.drive_amp === 1'b1);
      kw += int'(o_trig.inj_kicker === 1'b1);
      cw += int'(o_trig.chopper === 1'b1);
      sw += int'(o_trig.septum === 1'b1);
      ne += int'(o_trig.extr_kicker === 1'b1);
      if (o_trig.modulator === 1'b1) t_m = n;
      if (o_trig.modulator === 1'b1 && mw == 1) t_m0 = n;
      if (o_trig.inj_kicker === 1'b1 && kw == 1) t_k0 = n;
      if (o_fiducial === 1'b1) t_f = n;
      if (o_trig.extr_kicker === 1'b1) t_e = n;
      if (o_trig.ring_kicker[0] === 1'b1) t_r0 = n;
      if (o_trig.ring_kicker[2] === 1'b1) t_r2 = n;
    end
    `CHK("mod_width", 400, mw)
    `CHK("drive_width", 400, dw)
    `CHK("kick_width", 20, kw)
    `CHK("chop_width", 20, cw)
    `CHK("septum_width", 20, sw)
    `CHK("kick_lead", 54, t_k0 - t_m0)
    // fiducials recur every 744 cycles; ring ticks come every second cycle
    `CHK("bucket_delay", 0, ((t_m0 - t_f - 2 * int'(bkt) - 12) % 744 + 744) % 744)
    `CHK("extr_count", 1, ne)
    `CHK("extr_order", 1, int'(t_e - t_m > 1500 && t_r0 > t_e))
    `CHK("ring_span", 2 * (int'(i_ring_kick_gap) + 1), t_r2 - t_r0)
    `CHK("refused_arm", 1'b0, o_busy)
  endtask
  initial begin
    repeat (16) @(posedge i_clk_sys);
    #1;
    t_quiet();
    @(posedge i_clk_sys) i_reset_n <= 1'b1;
    tick();
    t_quiet();
    t_fid();
    t_fill(9'h64, 8'h5a);
    t_fill(9'h173, 8'h3c);
    summarize();
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    bad_count++;
    summarize();
  end
endmodule
